//--- hw/reset_init_sequencer.sv
/*
  Reset initialization sequencer: strap capture, lock wait, hard and soft reset drive.
  Assumes synchronous inputs, open-drain reset pins resolved outside, and the
  board keeping the input-side hold and setup times.
*/
// Behaviour
// R1 - The board holds the hard or soft reset input low for at least 32 bus sync periods.
// R2 - In host mode the board holds power-on reset for at least 32 primary clock periods.
// R3 - In agent mode the board holds power-on reset for at least 32 bus sync periods.
// R4 - The device drives hard and soft reset low for at least 512 bus sync periods.
// R5 - The device releases soft reset at least 16 bus sync periods after hard reset.
// R6 - The board keeps the straps stable 4 clock periods before power-on reset release.
// R7 - Strap drive stops with hard reset and resumes at least 1 bus sync period after it.
// R8 - The DLL is given 7680 to 122880 bus clock cycles to lock.
// R9 - The straps are a three-bit reset source field and one clock divider bit.
// R10 - In host mode the bus sync period is the primary clock divided per the divider strap.
// R11 - Internal logic stays in reset until PLL and DLL lock, then resets release in order.
`timescale 1ns/10ps
`include "reset_init_map.svh"

module reset_init_sequencer
  import reset_init_pkg::*;
#(
  parameter int PLL_LOCK_CYC = `PLL_LOCK_MAX_CYC,
  parameter int DLL_MIN_CYC = `DLL_LOCK_MIN_CYC,
  parameter int DLL_MAX_CYC = `DLL_LOCK_MAX_CYC,
  parameter int LOCK_W = 17
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic hostMode,
  input wire logic busSyncClk,
  input wire logic powerOnResetLine_n,
  input wire logic hardResetLineIn,
  output logic hardResetLineOut,
  output logic hardResetLineOe,
  input wire logic softResetLineIn,
  output logic softResetLineOut,
  output logic softResetLineOe,
  input wire logic [`STRAP_WIDTH-1:0] strapIn,
  output logic [`STRAP_WIDTH-1:0] strapOut,
  output logic strapOe,
  input wire logic pllLock,
  input wire logic dllLock,
  output logic [`STRAP_SRC_WIDTH-1:0] resetSource,
  output logic inputClockDividerStrap,
  output logic coreReset_n,
  output logic pllLockFail,
  output logic dllLockFail
);
  localparam logic [5:0] EXT_MIN = 6'(`EXT_RST_MIN_TICKS);
  localparam logic [9:0] HARD_MIN = 10'(`HARD_OUT_MIN_TICKS);
  localparam logic [9:0] SOFT_LAG = 10'(`SOFT_LAG_MIN_TICKS);
  localparam logic [9:0] STRAP_ON = 10'(`STRAP_ON_MIN_TICKS);
  localparam logic [LOCK_W-1:0] PLL_LIM = LOCK_W'(PLL_LOCK_CYC);
  localparam logic [LOCK_W-1:0] DLL_MIN = LOCK_W'(DLL_MIN_CYC);
  localparam logic [LOCK_W-1:0] DLL_LIM = LOCK_W'(DLL_MAX_CYC);

  seq_state_t state_q, state_d;
  strap_t strap_q, strap_d;
  logic divPhase_q, divPhase_d;
  logic syncPrev_q;
  logic tick;
  logic extLow;
  logic hardOe_d, softOe_d, strapOe_d, coreRst_d, pllFail_d, dllFail_d;
  logic hardOe_q, softOe_q, strapOe_q, coreRst_q, pllFail_q, dllFail_q;

  timer_if #(.W(10)) syncT ();
  timer_if #(.W(LOCK_W)) lockT ();
  timer_if #(.W(6)) extT ();

  // ****************************************************************
  // Timers
  // ****************************************************************

  // Bus sync periods in the current phase
  cycle_timer #(.W(10)) u_syncTimer (.clk(clk), .arst_n(arst_n), .t(syncT));
  // Bus clock cycles spent waiting for lock
  cycle_timer #(.W(LOCK_W)) u_lockTimer (.clk(clk), .arst_n(arst_n), .t(lockT));
  // Bus sync periods an outside party holds a reset line low
  cycle_timer #(.W(6)) u_extTimer (.clk(clk), .arst_n(arst_n), .t(extT));

  // ****************************************************************
  // Bus sync tick
  // ****************************************************************

  // Host divides the primary clock by 1 or 2, agent uses the sync input edge
  always_comb begin
    divPhase_d = (hostMode && strap_q.clkinDiv) ? ~divPhase_q : 1'b0; // R10
    if (hostMode) begin
      tick = !strap_q.clkinDiv || divPhase_q; // R10
    end else begin
      tick = busSyncClk && !syncPrev_q;
    end
  end

  // Divider phase and sync edge history
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      divPhase_q <= 1'b0;
      syncPrev_q <= 1'b0;
    end else begin
      divPhase_q <= divPhase_d;
      syncPrev_q <= busSyncClk;
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************

  // Outside reset request seen only while the device itself is not driving
  assign extLow = (!hardResetLineIn || !softResetLineIn) && (state_q == S_RUN);
  assign extT.clr = !extLow;
  assign extT.en = tick;

  // Next state, timer control and registered outputs
  always_comb begin
    state_d = state_q;
    strap_d = strap_q;
    syncT.clr = 1'b0;
    syncT.en = tick;
    lockT.clr = 1'b0;
    lockT.en = (state_q == S_HARD);
    unique case (state_q)
      S_POR: begin
        syncT.clr = 1'b1;
        lockT.clr = 1'b1;
        if (powerOnResetLine_n) begin
          strap_d = strap_t'(strapIn); // R9
          state_d = S_HARD;
        end
      end
      S_HARD: begin
        if ((syncT.cnt >= HARD_MIN) && pllLock && dllLock && (lockT.cnt >= DLL_MIN)) begin
          syncT.clr = 1'b1; // R4 R8 R11
          state_d = S_SOFT;
        end
      end
      S_SOFT: begin
        if (syncT.cnt >= SOFT_LAG) begin
          state_d = S_RUN; // R5
        end
      end
      S_RUN: begin
        if (extT.cnt >= EXT_MIN) begin
          syncT.clr = 1'b1;
          lockT.clr = 1'b1;
          state_d = S_HARD;
        end
      end
    endcase
    if (!powerOnResetLine_n) begin
      state_d = S_POR;
    end
    hardOe_d = (state_d == S_POR) || (state_d == S_HARD); // R4
    softOe_d = hardOe_d || (state_d == S_SOFT); // R5
    coreRst_d = (state_d == S_RUN); // R11
    strapOe_d = hardResetLineIn && !hardOe_q &&
                ((state_q == S_RUN) || ((state_q == S_SOFT) && (syncT.cnt >= STRAP_ON))); // R7
    pllFail_d = pllFail_q;
    dllFail_d = dllFail_q;
    if (state_q == S_HARD) begin
      pllFail_d = pllFail_q || (!pllLock && (lockT.cnt >= PLL_LIM));
      dllFail_d = dllFail_q || (!dllLock && (lockT.cnt >= DLL_LIM)); // R8
    end else if (state_q == S_POR) begin
      pllFail_d = 1'b0;
      dllFail_d = 1'b0;
    end
  end

  // State and output registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= S_POR;
      strap_q <= strap_t'(`STRAP_RST);
      hardOe_q <= 1'b1;
      softOe_q <= 1'b1;
      strapOe_q <= 1'b0;
      coreRst_q <= 1'b0;
      pllFail_q <= 1'b0;
      dllFail_q <= 1'b0;
    end else begin
      state_q <= state_d;
      strap_q <= strap_d;
      hardOe_q <= hardOe_d;
      softOe_q <= softOe_d;
      strapOe_q <= strapOe_d;
      coreRst_q <= coreRst_d;
      pllFail_q <= pllFail_d;
      dllFail_q <= dllFail_d;
    end
  end

  // Open-drain reset pins pull low only, straps read back the captured set
  assign hardResetLineOut = 1'b0;
  assign softResetLineOut = 1'b0;
  assign hardResetLineOe = hardOe_q;
  assign softResetLineOe = softOe_q;
  assign strapOut = strap_q;
  assign strapOe = strapOe_q;
  assign resetSource = strap_q.resetSource;
  assign inputClockDividerStrap = strap_q.clkinDiv;
  assign coreReset_n = coreRst_q;
  assign pllLockFail = pllFail_q;
  assign dllLockFail = dllFail_q;

  // ****************************************************************
  // Checks
  // ****************************************************************

  logic [9:0] hardTicks_q, lagTicks_q;

  // Ticks counted while hard reset is driven, and since it was released
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hardTicks_q <= '0;
      lagTicks_q <= '0;
    end else begin
      hardTicks_q <= !hardOe_q ? '0 : hardTicks_q + 10'(tick && (hardTicks_q != 10'h3FF));
      lagTicks_q <= hardOe_q ? '0 : lagTicks_q + 10'(tick && (lagTicks_q != 10'h3FF));
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence hardReleased;
    $fell(hardOe_q);
  endsequence

  sequence softReleased;
    $fell(softOe_q);
  endsequence

  // Divided host tick seen, with mode and divider strap still unchanged one cycle on
  sequence divTickSeen;
    (hostMode && strap_q.clkinDiv && tick) ##1 (hostMode && strap_q.clkinDiv);
  endsequence

  chk_hard_hold_min: assert property (hardReleased |-> $past(hardTicks_q) >= HARD_MIN) // R4
    else $error("hard reset released too early");
  chk_soft_after_hard: assert property (softReleased |-> !hardOe_q && $past(lagTicks_q) >= SOFT_LAG) // R5
    else $error("soft reset released too soon after hard");
  chk_strap_off_hard: assert property ((hardOe_q || !hardResetLineIn) |=> !strapOe_q) // R7
    else $error("straps driven during hard reset");
  chk_strap_on_late: assert property ($rose(strapOe_q) |-> $past(lagTicks_q) >= STRAP_ON) // R7
    else $error("straps driven too soon after hard reset");
  chk_dll_lock_min: assert property (hardReleased |-> $past(lockT.cnt) >= DLL_MIN && $past(dllLock)) // R8
    else $error("left hard reset before dll lock window");
  chk_strap_capture: assert property ((state_q == S_POR && powerOnResetLine_n) |=> strap_q == $past(strapIn)) // R9
    else $error("straps not captured at power-on release");
  chk_host_divider: assert property (divTickSeen |-> !tick) // R10
    else $error("host divider tick rate wrong");
  chk_lock_gate: assert property ((state_q == S_HARD && !(pllLock && dllLock) && powerOnResetLine_n) |=> state_q == S_HARD) // R11
    else $error("sequence advanced without lock");
  chk_core_order: assert property ($rose(coreRst_q) |-> !softOe_q && !hardOe_q) // R11
    else $error("core released before reset lines");
endmodule // reset_init_sequencer

//--- hw/reset_init_map.svh
/*
  Clock rate, strap field positions, reset values and timing counts of the reset sequencer.
  Assumes a 50 MHz system clock that also serves as the coherent bus clock.
*/
`ifndef RESET_INIT_MAP_SVH
`define RESET_INIT_MAP_SVH

// ****************************************************************
// Clock
// ****************************************************************
`define CLK_MHZ 50

// ****************************************************************
// Counts in bus sync clock periods
// ****************************************************************
`define EXT_RST_MIN_TICKS 32
`define HARD_OUT_MIN_TICKS 512
`define SOFT_LAG_MIN_TICKS 16
`define STRAP_ON_MIN_TICKS 1

// ****************************************************************
// Lock times
// ****************************************************************
`define PLL_LOCK_MAX_US 100
`define PLL_LOCK_MAX_CYC (`PLL_LOCK_MAX_US * `CLK_MHZ)
`define DLL_LOCK_MIN_CYC 7680
`define DLL_LOCK_MAX_CYC 122880

// ****************************************************************
// Strap layout and reset value
// ****************************************************************
`define STRAP_WIDTH 4
`define STRAP_SRC_LSB 0
`define STRAP_SRC_WIDTH 3
`define STRAP_DIV_BIT 3
`define STRAP_RST 4'h0

`endif

//--- hw/reset_init_pkg.sv
/*
  Types of the reset sequencer: state codes and the strap record.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package reset_init_pkg;

  // ****************************************************************
  // Sequencer states, one-hot
  // ****************************************************************
  typedef enum logic [3:0] {
    S_POR  = 4'h1,
    S_HARD = 4'h2,
    S_SOFT = 4'h4,
    S_RUN  = 4'h8
  } seq_state_t;

  // ****************************************************************
  // Captured configuration straps
  // ****************************************************************
  typedef struct packed {
    logic clkinDiv;
    logic [2:0] resetSource;
  } strap_t;

endpackage

//--- hw/timer_if.sv
/*
  Carrier between the sequencer and its cycle timers: clear, count enable and count.
  Assumes the timer and its user share one clock.
*/
`timescale 1ns/10ps

interface timer_if #(parameter int W = 8);
  logic clr;
  logic en;
  logic [W-1:0] cnt;
  modport ctl (output clr, output en, input cnt);
  modport tmr (input clr, input en, output cnt);
endinterface

//--- hw/cycle_timer.sv
/*
  Saturating up counter with synchronous clear and count enable.
  Assumes a single clock and an active-low asynchronous reset.
*/
`timescale 1ns/10ps

module cycle_timer #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic arst_n,
  timer_if.tmr t
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  // ****************************************************************
  // Count logic
  // ****************************************************************

  // Clear wins, count stops at all ones so it never wraps
  always_comb begin
    cnt_d = cnt_q;
    if (t.clr) begin
      cnt_d = '0;
    end else if (t.en && (cnt_q != {W{1'b1}})) begin
      cnt_d = cnt_q + W'(1);
    end
  end

  // Counter register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign t.cnt = cnt_q;
endmodule // cycle_timer

//--- test/board_reset_ctl.sv
/*
  Board model: power-on and outside reset drivers, free running sync clock, straps, lines.
  Assumes the bench pulses porReq and extReq high for one clk cycle.
*/
`timescale 1ns/10ps

module board_reset_ctl (
  input wire logic clk,
  input wire logic porReq,
  input wire logic extReq,
  input wire logic extSoft,
  input wire logic [7:0] extLen,
  input wire logic [3:0] strapVal,
  input wire logic hardOe,
  input wire logic hardOut,
  input wire logic softOe,
  input wire logic softOut,
  input wire logic strapOe,
  input wire logic [3:0] strapOut,
  output logic powerOnResetLine_n,
  output logic busSyncClk,
  output logic hardLine,
  output logic softLine,
  output logic [3:0] strapLine
);
  int porCnt = 160;
  int extCnt = 0;
  logic [1:0] phase = 2'h0;

  // ********
  // Reset pulse lengths, sync clock of four clk periods
  // ********
  always @(posedge clk) begin
    phase <= phase + 2'h1;
    porCnt <= porReq ? 160 : (porCnt > 0 ? porCnt - 1 : 0);
    extCnt <= extReq ? int'(extLen) : (extCnt > 0 ? extCnt - 1 : 0);
  end

  // Open-drain lines with pull-ups; released straps show the board resistors
  assign busSyncClk = phase[1];
  assign powerOnResetLine_n = (porCnt == 0);
  assign hardLine = !((hardOe && !hardOut) || (extCnt > 0 && !extSoft));
  assign softLine = !((softOe && !softOut) || (extCnt > 0 && extSoft));
  assign strapLine = strapOe ? strapOut : strapVal;
endmodule // board_reset_ctl

//--- test/tb_reset_init_sequencer.sv
/*
  Self-checking bench of the reset sequencer, lock counts shortened.
  Assumes the board model board_reset_ctl and a 50 MHz clock.
*/
`timescale 1ns/10ps

`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin miscompares++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (a), (b)); end end

module tb_reset_init_sequencer;
  typedef struct {logic host; logic [3:0] strap; int p;} row_t;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic hostMode = 1'b1;
  logic pllLock = 1'b1;
  logic dllLock = 1'b1;
  logic porReq = 1'b0;
  logic extReq = 1'b0;
  logic extSoft = 1'b0;
  logic [7:0] extLen = 8'h00;
  logic [3:0] strapVal = 4'h0;
  logic [3:0] strapOut, strapLine;
  logic [2:0] resetSource;
  logic busSyncClk, powerOnResetLine_n, hardLine, softLine, hardOe, hardOut, softOe, softOut;
  logic strapOe, divStrap, coreReset_n, pllFail, dllFail;
  int miscompares = 0;
  int n_compared = 0;
  row_t rows [4] = '{'{1'b1, 4'h5, 1}, '{1'b1, 4'hA, 2}, '{1'b0, 4'h3, 4}, '{1'b0, 4'hE, 4}};

  // Clock of 20 ns
  always #10 clk = ~clk;

  // ********
  // Design and board
  // ********
  reset_init_sequencer #(.PLL_LOCK_CYC(20), .DLL_MIN_CYC(8), .DLL_MAX_CYC(60), .LOCK_W(17)) uut (
    .clk(clk), .arst_n(arst_n), .hostMode(hostMode), .busSyncClk(busSyncClk),
    .powerOnResetLine_n(powerOnResetLine_n), .hardResetLineIn(hardLine),
    .hardResetLineOut(hardOut), .hardResetLineOe(hardOe), .softResetLineIn(softLine),
    .softResetLineOut(softOut), .softResetLineOe(softOe), .strapIn(strapLine),
    .strapOut(strapOut), .strapOe(strapOe), .pllLock(pllLock), .dllLock(dllLock),
    .resetSource(resetSource), .inputClockDividerStrap(divStrap), .coreReset_n(coreReset_n),
    .pllLockFail(pllFail), .dllLockFail(dllFail));
  board_reset_ctl board (
    .clk(clk), .porReq(porReq), .extReq(extReq), .extLen(extLen), .strapVal(strapVal),
    .extSoft(extSoft),
    .hardOe(hardOe), .hardOut(hardOut), .softOe(softOe), .softOut(softOut),
    .strapOe(strapOe), .strapOut(strapOut), .powerOnResetLine_n(powerOnResetLine_n),
    .busSyncClk(busSyncClk), .hardLine(hardLine), .softLine(softLine),
    .strapLine(strapLine));

  // ********
  // Tasks
  // ********
  task automatic end_sim();
    $display("Compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Counts cycles while a flag keeps its level; a used-up bound ends the run
  task automatic hold_len(ref logic sig, input logic lvl, input int lim, output int n);
    n = 0;
    while (sig === lvl && n < lim) begin
      step(1);
      n++;
    end
    if (n >= lim) begin
      miscompares++;
      end_sim();
    end
  endtask

  task automatic chk_reset();
    `CHK({hardOe, softOe, strapOe, coreReset_n, pllFail, dllFail, resetSource, divStrap}, 10'h300)
    `CHK({hardOut, softOut}, 2'b00)
  endtask

  // Straps settle well before the board lets power-on reset go
  task automatic por_seq(input logic host, input logic [3:0] s);
    int n;
    @(posedge clk);
    hostMode <= host;
    strapVal <= s;
    porReq <= 1'b1;
    @(posedge clk);
    porReq <= 1'b0;
    #1;
    hold_len(powerOnResetLine_n, 1'b0, 400, n);
  endtask

  task automatic ext_pulse(input logic [7:0] len);
    @(posedge clk);
    extLen <= len;
    extReq <= 1'b1;
    @(posedge clk);
    extReq <= 1'b0;
  endtask

  // Hard phase, soft lag, strap drive and captured fields
  task automatic seq_check(input int p, input logic [3:0] s, input int hmin);
    int nh, ns;
    `CHK(coreReset_n, 1'b0)
    hold_len(hardOe, 1'b1, 3000, nh);
    `CHK(nh >= hmin && nh <= 514 * p + 4, 1'b1)
    `CHK(strapOe, 1'b0)
    hold_len(softOe, 1'b1, 200, ns);
    `CHK(ns >= 15 * p + 1 && ns <= 18 * p + 4, 1'b1)
    `CHK({coreReset_n, strapOe, strapOut, strapLine}, {2'b11, s, s})
    `CHK({divStrap, resetSource}, s)
  endtask

  // ********
  // Main sequence
  // ********
  initial begin
    int n;
    step(11);
    chk_reset();
    @(posedge clk);
    arst_n <= 1'b1;
    foreach (rows[i]) begin
      por_seq(rows[i].host, rows[i].strap);
      seq_check(rows[i].p, rows[i].strap, 511 * rows[i].p + 1);
    end
    // Locks arrive late: hard reset holds, fail flags after their counts
    @(posedge clk);
    pllLock <= 1'b0;
    dllLock <= 1'b0;
    por_seq(1'b1, 4'h6);
    step(15);
    `CHK({pllFail, dllFail}, 2'b00)
    step(10);
    `CHK({pllFail, dllFail}, 2'b10)
    step(40);
    `CHK({pllFail, dllFail}, 2'b11)
    step(500);
    `CHK(hardOe, 1'b1)
    @(posedge clk);
    pllLock <= 1'b1;
    dllLock <= 1'b1;
    #1;
    seq_check(1, 4'h6, 0);
    // Outside hard reset: too short is ignored, long enough restarts
    ext_pulse(8'd20);
    step(40);
    `CHK({hardOe, coreReset_n}, 2'b01)
    ext_pulse(8'd60);
    step(2);
    `CHK(strapOe, 1'b0)
    hold_len(hardOe, 1'b0, 100, n);
    `CHK(n >= 30, 1'b1)
    seq_check(1, 4'h6, 510);
    // Outside soft reset long enough restarts the full sequence too
    @(posedge clk);
    extSoft <= 1'b1;
    ext_pulse(8'd60);
    hold_len(hardOe, 1'b0, 100, n);
    `CHK(n >= 30, 1'b1)
    seq_check(1, 4'h6, 510);
    // Second reset in mid-run
    @(posedge clk);
    arst_n <= 1'b0;
    step(2);
    chk_reset();
    end_sim();
  end
endmodule // tb_reset_init_sequencer
